// File: verilog/pwm_tb_pkg.sv
// Shared constants and types for the PWM primary time base
package pwm_tb_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_ACTIVE = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_COMPARE = 8'h18;

  // Control register field positions
  localparam int BIT_ON = 15;
  localparam int BIT_IDLE_HALT = 13;
  localparam int BIT_SE_PEND = 12;
  localparam int BIT_SE_IRQ = 11;
  localparam int BIT_IMM = 10;
  localparam int BIT_INV = 9;
  localparam int BIT_SOUT = 8;
  localparam int BIT_EXT = 7;
  localparam int SRC_HI = 6;
  localparam int SRC_LO = 4;
  localparam int PS_HI = 3;
  localparam int PS_LO = 0;
  localparam int PS_W = 4;
  localparam int SRC_N = 8;

  // Writable control bits: all but the pending flag and bit 14
  localparam logic [15:0] CTRL_WMASK = 16'hafff;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hffff;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;

  // Interrupt status bit positions
  localparam int ST_SPECIAL = 0;
  localparam int ST_CYCLE = 1;
  localparam int ST_SYNC = 2;
  localparam int ST_W = 3;

  // Time base state, Gray coded along off, run, halt
  typedef enum logic [1:0] {
    TB_OFF = 2'b00,
    TB_RUN = 2'b01,
    TB_HALT = 2'b11
  } tb_mode_t;

endpackage : pwm_tb_pkg

// File: verilog/pscl_if.sv
// Link between the time base and its special event postscaler
`timescale 1ns/1ns
interface pscl_if;
  import pwm_tb_pkg::*;
  logic tick;
  logic clear;
  logic [PS_W-1:0] ratio;
  logic fire;
  modport owner (output tick, clear, ratio, input fire);
  modport counter (input tick, clear, ratio, output fire);
endinterface : pscl_if

// File: verilog/pin_sync.sv
// Two-stage synchroniser for asynchronous input pins
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1 // Number of pins
) (
  input wire logic clk, // Clock
  input wire logic srst, // Synchronous reset
  input wire logic [W-1:0] d, // Raw pins
  output logic [W-1:0] q // Synchronised pins
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // First stage feeds only the second
  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule : pin_sync

// File: verilog/event_postscaler.sv
// Divider that passes one of every ratio+1 special event ticks
`timescale 1ns/1ns
module event_postscaler
  import pwm_tb_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic srst, // Synchronous reset
  pscl_if.counter ps // Tick in, fire out
);
  typedef struct packed {
    logic [PS_W-1:0] count;
    logic fire;
  } ps_state_t;

  ps_state_t st;
  ps_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.fire = 1'b0;
    if (ps.clear) begin
      next_st.count = '0;
    end else if (ps.tick) begin
      if (st.count >= ps.ratio) begin
        next_st.count = '0;
        next_st.fire = 1'b1;
      end else begin
        next_st.count = st.count + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ps.fire = st.fire;

  a_fire_on_ratio: assert property (@(posedge clk) disable iff (srst)
    ps.tick && !ps.clear && st.count == ps.ratio |=> st.fire)
    else $error("postscaler did not fire at ratio");

  a_no_early_fire: assert property (@(posedge clk) disable iff (srst)
    ps.tick && !ps.clear && st.count < ps.ratio |=> !st.fire)
    else $error("postscaler fired early");
endmodule : event_postscaler

// File: verilog/pwm_time_base.sv
// PWM primary time base: control register, sync in/out, special event
`timescale 1ns/1ns
module pwm_time_base
  import pwm_tb_pkg::*;
#(
  parameter logic [15:0] PERIOD_INIT = PERIOD_RESET // Period after reset
) (
  input wire logic CLK, // 20 MHz clock
  input wire logic SRST, // Synchronous reset, active high
  input wire logic CYC_I, // Wishbone cycle
  input wire logic STB_I, // Wishbone strobe
  input wire logic WE_I, // Wishbone write
  input wire logic [7:0] ADR_I, // Wishbone byte address
  input wire logic [3:0] SEL_I, // Wishbone byte selects
  input wire logic [31:0] DAT_I, // Wishbone write data
  output logic [31:0] DAT_O, // Wishbone read data
  output logic ACK_O, // Wishbone acknowledge
  input wire logic [SRC_N-1:0] SYNC_IN, // External sync pins
  input wire logic CPU_IDLE, // CPU idle indication
  output logic SYNC_OUT, // Sync output pin level
  output logic SYNC_OUT_OE, // Sync output drive enable
  output logic SPECIAL_EVENT_TRIG, // Postscaled special event pulse
  output logic [15:0] TB_COUNT, // Time base count
  output logic IRQ // Interrupt, active high level
);

  typedef struct packed {
    tb_mode_t tb;
    logic [15:0] ctrl;
    logic [15:0] period_buf;
    logic [15:0] period_act;
    logic [15:0] compare;
    logic [15:0] count;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic prev_sync;
    logic sync_out;
    logic sync_oe;
    logic trig;
    logic irq;
    logic ack;
    logic [31:0] rdata;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;

  logic [SRC_N:0] pins_q;
  logic idle_q;
  logic [SRC_N-1:0] sync_q;
  logic [SRC_N-1:0] sync_pol;
  logic sync_active;
  logic sync_edge;
  logic run;
  logic boundary;
  logic se_set;
  logic acc;
  logic wr;
  logic [15:0] ctrl_view;
  logic [15:0] wdata;
  logic [ST_W-1:0] st_set;
  logic [ST_W-1:0] st_clr;

  pscl_if pscl ();

  // Pins come from outside the clock domain
  pin_sync #(
    .W(SRC_N + 1)
  ) u_pin_sync (
    .clk(CLK),
    .srst(SRST),
    .d({CPU_IDLE, SYNC_IN}),
    .q(pins_q)
  );

  event_postscaler u_postscaler (
    .clk(CLK),
    .srst(SRST),
    .ps(pscl.counter)
  );

  assign idle_q = pins_q[SRC_N];
  assign sync_q = pins_q[SRC_N-1:0];

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [15:0] nw,
                                           input logic [1:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = nw[7:0];
    end
    if (sel[1]) begin
      res[15:8] = nw[15:8];
    end
    return res;
  endfunction : merge16

  // Control view with the pending flag folded in
  always_comb begin
    ctrl_view = st.ctrl & CTRL_WMASK;
    ctrl_view[BIT_SE_PEND] = st.status[ST_SPECIAL];
  end

  // Selected sync input, polarity and edge
  always_comb begin
    sync_pol = sync_q ^ {SRC_N{st.ctrl[BIT_INV]}};
    sync_active = sync_pol[st.ctrl[SRC_HI:SRC_LO]];
    sync_edge = st.ctrl[BIT_EXT] && sync_active && !st.prev_sync;
    run = st.tb == TB_RUN;
    boundary = run && (sync_edge || st.count >= st.period_act);
  end

  // Postscaler feed: counter match while running
  assign pscl.tick = run && st.count == st.compare;
  assign pscl.ratio = st.ctrl[PS_HI:PS_LO];
  assign pscl.clear = !st.ctrl[BIT_ON];

  // Bus strobes; the write lands on the edge that sees ack
  assign acc = CYC_I && STB_I && st.ack;
  assign wr = acc && WE_I;
  assign wdata = DAT_I[15:0];

  // Event sources and software clears of status
  always_comb begin
    se_set = pscl.fire && st.ctrl[BIT_SE_IRQ];
    st_set = '0;
    st_set[ST_SPECIAL] = se_set;
    st_set[ST_CYCLE] = boundary;
    st_set[ST_SYNC] = run && sync_edge;
    st_clr = '0;
    if (wr && ADR_I == OFS_STATUS && SEL_I[0]) begin
      st_clr = DAT_I[ST_W-1:0];
    end
  end

  // Next state of the whole block
  always_comb begin
    next_st = st;
    next_st.prev_sync = sync_active;

    if (!st.ctrl[BIT_ON]) begin
      next_st.tb = TB_OFF;
    end else if (st.ctrl[BIT_IDLE_HALT] && idle_q) begin
      next_st.tb = TB_HALT;
    end else begin
      next_st.tb = TB_RUN;
    end

    if (!st.ctrl[BIT_ON]) begin
      next_st.count = '0;
    end else if (boundary) begin
      next_st.count = '0;
    end else if (run) begin
      next_st.count = st.count + 16'h0001;
    end

    if (boundary && !st.ctrl[BIT_IMM]) begin
      next_st.period_act = st.period_buf;
    end

    // Sync output pulse at each boundary
    // output polarity
    next_st.sync_out = boundary ^ st.ctrl[BIT_INV];
    next_st.sync_oe = st.ctrl[BIT_SOUT];

    next_st.trig = pscl.fire;

    // Set wins over a clear in the same cycle
    // pending flag owned by hardware
    next_st.status = (st.status & ~st_clr) | st_set;

    // Register writes
    if (wr) begin
      case (ADR_I)
        OFS_CTRL: begin
          // bit 14 and pending flag not stored
          next_st.ctrl = merge16(st.ctrl, wdata, SEL_I[1:0]) & CTRL_WMASK;
        end
        OFS_PERIOD: begin
          next_st.period_buf = merge16(st.period_buf, wdata, SEL_I[1:0]);
          if (st.ctrl[BIT_IMM]) begin
            next_st.period_act = merge16(st.period_buf, wdata, SEL_I[1:0]);
          end
        end
        OFS_MASK: begin
          if (SEL_I[0]) begin
            next_st.mask = DAT_I[ST_W-1:0];
          end
        end
        OFS_COMPARE: begin
          next_st.compare = merge16(st.compare, wdata, SEL_I[1:0]);
        end
        default: begin
          next_st.mask = next_st.mask;
        end
      endcase
    end

    next_st.irq = |(next_st.status & next_st.mask);

    // Wishbone ack one cycle after the strobe, dropped after one
    next_st.ack = CYC_I && STB_I && !st.ack;
    next_st.rdata = '0;
    if (CYC_I && STB_I && !st.ack && !WE_I) begin
      case (ADR_I)
        OFS_CTRL: next_st.rdata = {16'h0000, ctrl_view};
        OFS_PERIOD: next_st.rdata = {16'h0000, st.period_buf};
        OFS_ACTIVE: next_st.rdata = {16'h0000, st.period_act};
        OFS_COUNT: next_st.rdata = {16'h0000, st.count};
        OFS_STATUS: next_st.rdata = {29'h0000000, st.status};
        OFS_MASK: next_st.rdata = {29'h0000000, st.mask};
        OFS_COMPARE: next_st.rdata = {16'h0000, st.compare};
        default: next_st.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st.tb <= TB_OFF;
      st.ctrl <= CTRL_RESET;
      st.period_buf <= PERIOD_INIT;
      st.period_act <= PERIOD_INIT;
      st.compare <= COMPARE_RESET;
      st.count <= 16'h0000;
      st.status <= '0;
      st.mask <= '0;
      st.prev_sync <= 1'b0;
      st.sync_out <= 1'b0;
      st.sync_oe <= 1'b0;
      st.trig <= 1'b0;
      st.irq <= 1'b0;
      st.ack <= 1'b0;
      st.rdata <= 32'h00000000;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign DAT_O = st.rdata;
  assign ACK_O = st.ack;
  assign SYNC_OUT = st.sync_out;
  assign SYNC_OUT_OE = st.sync_oe;
  assign SPECIAL_EVENT_TRIG = st.trig;
  assign TB_COUNT = st.count;
  assign IRQ = st.irq;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  sequence s_ctrl_read;
    CYC_I && STB_I && !ACK_O && !WE_I && ADR_I == OFS_CTRL;
  endsequence

  sequence s_period_write;
    wr && ADR_I == OFS_PERIOD && SEL_I[1:0] == 2'b11;
  endsequence

  a_bit14_zero: assert property (s_ctrl_read |=> ACK_O && !DAT_O[14])
    else $error("bit 14 read as one");

  a_pending_read: assert property (s_ctrl_read |=>
    DAT_O[BIT_SE_PEND] == $past(st.status[ST_SPECIAL]))
    else $error("pending flag readback wrong");

  // module off holds count at zero
  a_off_count: assert property (!st.ctrl[BIT_ON] |=> st.count == 16'h0000)
    else $error("count moved while module off");

  // halted time base holds its count
  a_halt_holds: assert property (st.tb == TB_HALT && st.ctrl[BIT_ON]
    |=> st.count == $past(st.count))
    else $error("count moved while halted in idle");

  // idle ignored when halt bit clear
  a_idle_runs: assert property (st.ctrl[BIT_ON] && !st.ctrl[BIT_IDLE_HALT]
    |=> st.tb == TB_RUN)
    else $error("time base stopped without idle halt");

  // disabled special events never set pending
  a_se_blocked: assert property (!st.ctrl[BIT_SE_IRQ] && !st.status[ST_SPECIAL]
    |=> !st.status[ST_SPECIAL])
    else $error("special event pending while disabled");

  a_se_pending: assert property (pscl.fire && st.ctrl[BIT_SE_IRQ]
    |=> st.status[ST_SPECIAL])
    else $error("special event not pending");

  a_imm_update: assert property (s_period_write ##0 st.ctrl[BIT_IMM]
    |=> st.period_act == $past(wdata))
    else $error("immediate period update missed");

  a_boundary_only: assert property (!st.ctrl[BIT_IMM] && !boundary
    |=> $stable(st.period_act))
    else $error("active period changed off boundary");

  // sync output active level at boundary
  a_sync_pulse: assert property (boundary
    |=> SYNC_OUT == !$past(st.ctrl[BIT_INV]))
    else $error("sync output level wrong at boundary");

  a_sync_oe: assert property (1'b1 |=> SYNC_OUT_OE == $past(st.ctrl[BIT_SOUT]))
    else $error("sync output enable wrong");

  a_ext_restart: assert property (run && sync_edge |=> st.count == 16'h0000)
    else $error("external sync did not restart count");

  a_reset_ctrl: assert property ($fell(SRST) |-> st.ctrl == CTRL_RESET)
    else $error("control not zero after reset");

endmodule : pwm_time_base

// File: verilog/end.sv
// Intentionally empty file kept out of compile
`timescale 1ns/1ns

// File: dv/sync_partner.sv
// Far side model: external sync source and sync output watcher
`timescale 1ns/1ns
module sync_partner (
  input wire logic clk, // Clock
  input wire logic invert, // Active-low sync levels
  input wire logic [2:0] pin_sel, // Pin to pulse
  input wire logic fire, // Start one pulse
  input wire logic watch, // Count output pulses
  input wire logic sync_out, // Sync output level
  input wire logic sync_oe, // Sync output enable
  output logic [7:0] pins, // Sync input pins
  output int seen // Output pulses counted
);
  logic [7:0] act = 8'h00;
  logic [1:0] hold = 2'd0;
  logic last = 1'b0;
  // pin levels follow the programmed polarity
  assign pins = invert ? ~act : act;
  // Three cycles active so the two-flop synchroniser cannot miss it
  always @(posedge clk) begin
    if (fire) begin
      act <= 8'h01 << pin_sel;
      hold <= 2'd2;
    end else if (hold != 2'd0) begin
      hold <= hold - 2'd1;
    end else begin
      act <= 8'h00;
    end
  end
  // Count entries into the active level, only while driven
  always @(negedge clk) begin
    last <= sync_out ^ invert;
    if (!watch) seen <= 0;
    else if (sync_oe && (sync_out ^ invert) && !last) seen <= seen + 1;
  end
endmodule : sync_partner

// File: dv/test_pwm_time_base.sv
// Self-checking bench for the PWM primary time base
`timescale 1ns/1ns
module test_pwm_time_base;
  import pwm_tb_pkg::*;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h00000000;
  logic idle = 1'b0, fire = 1'b0, inv = 1'b0, win = 1'b0;
  logic [2:0] psel = 3'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] rdat;
  logic ack, sout, soe, trig, irq;
  logic [15:0] cnt, q, c1;
  logic [7:0] pins;
  int seen, m, trig_n = 0, fail_count = 0, total_checks = 0;

  always #25 CLK = ~CLK;

  pwm_time_base #(.PERIOD_INIT(16'h000f)) i_dut (.CLK(CLK), .SRST(SRST),
    .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
    .DAT_I(dat), .DAT_O(rdat), .ACK_O(ack), .SYNC_IN(pins),
    .CPU_IDLE(idle), .SYNC_OUT(sout), .SYNC_OUT_OE(soe),
    .SPECIAL_EVENT_TRIG(trig), .TB_COUNT(cnt), .IRQ(irq));

  sync_partner i_far (.clk(CLK), .invert(inv), .pin_sel(psel),
    .fire(fire), .watch(win), .sync_out(sout), .sync_oe(soe),
    .pins(pins), .seen(seen));

  // Postscaled trigger pulses inside the window
  always @(negedge CLK) trig_n <= win ? trig_n + int'(trig === 1'b1) : 0;

  task automatic complete_run;
    $display("mismatches %0d, checks %0d", fail_count, total_checks);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input string n, input logic [15:0] e, g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Unknown values fail as well; a bare compare would let them through
  task automatic rng(input string n, input int lo, hi, input logic [31:0] v);
    total_checks++;
    if ($isunknown(v) || v < lo || v > hi) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", n, lo, hi, v);
    end
  endtask : rng

  // One classic cycle; ack and read data taken at the same rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h3;
    adr <= a;
    dat <= {16'h0000, d};
    @(posedge CLK);
    while (ack !== 1'b1) begin
      n++;
      if (n > 20) begin
        fail_count++;
        $display("CHECK FAILED bus ack expected 1 seen %b", ack);
        complete_run();
      end
      @(posedge CLK);
    end
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
    // Idle cycle so the next request cannot follow back to back
    @(posedge CLK);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 16'h0000);
  endtask : rd

  // settings written with the module off, then switched on
  task automatic cfg(input logic [15:0] c);
    wr(OFS_CTRL, c & 16'h7fff);
    wr(OFS_CTRL, c);
  endtask : cfg

  task automatic cnt_in(input string n, input int lo, hi);
    @(negedge CLK);
    rng(n, lo, hi, {16'h0000, cnt});
    @(posedge CLK);
  endtask : cnt_in

  task automatic pin_chk(input string n, input logic e, ref logic s);
    @(negedge CLK);
    chk(n, {15'h0000, e}, {15'h0000, s});
    @(posedge CLK);
  endtask : pin_chk

  task automatic window;
    win <= 1'b1;
    repeat (100) @(posedge CLK);
    win <= 1'b0;
  endtask : window

  task automatic pulse(input logic [2:0] p);
    psel <= p;
    fire <= 1'b1;
    @(posedge CLK);
    fire <= 1'b0;
    repeat (8) @(posedge CLK);
  endtask : pulse

  // Let the count climb well clear of zero before a sync pulse
  task automatic climb;
    for (int n = 0; n < 400 && !(cnt > 16'd40); n++) @(negedge CLK);
    @(posedge CLK);
  endtask : climb

  initial begin
    repeat (60000) @(posedge CLK);
    fail_count++;
    $display("CHECK FAILED run length expected end seen timeout");
    complete_run();
  end

  initial begin
    repeat (3) @(posedge CLK);
    SRST <= 1'b0;
    @(posedge CLK);
    rd(OFS_CTRL); chk("ctrl reset", 16'h0000, q);
    rd(OFS_ACTIVE); chk("active reset", 16'h000f, q);
    rd(8'h40); chk("unmapped read", 16'h0000, q);
    wr(OFS_CTRL, 16'h7fff); rd(OFS_CTRL); chk("ctrl rw", 16'h2fff, q);
    wr(OFS_CTRL, 16'h0400); wr(OFS_PERIOD, 16'h0007);
    rd(OFS_ACTIVE); chk("immediate period", 16'h0007, q);
    wr(OFS_CTRL, 16'h0000); wr(OFS_PERIOD, 16'h0009);
    rd(OFS_ACTIVE); chk("held period", 16'h0007, q);
    wr(OFS_CTRL, 16'h8000);
    repeat (20) @(posedge CLK);
    rd(OFS_ACTIVE); chk("boundary period", 16'h0009, q);
    m = 0;
    repeat (30) begin
      @(negedge CLK);
      if (int'(cnt) > m) m = int'(cnt);
    end
    @(posedge CLK);
    rng("count peak", 9, 9, m);
    wr(OFS_CTRL, 16'h0000);
    @(negedge CLK); c1 = cnt; repeat (5) @(negedge CLK);
    chk("count when off", 16'h0000, cnt);
    @(posedge CLK);
    wr(OFS_CTRL, 16'ha000); idle <= 1'b1;
    repeat (4) @(negedge CLK); c1 = cnt; repeat (5) @(negedge CLK);
    chk("halt in idle", c1, cnt);
    @(posedge CLK);
    wr(OFS_CTRL, 16'h8000);
    @(negedge CLK); c1 = cnt; repeat (3) @(negedge CLK);
    chk("run in idle", 16'h0001, {15'h0000, cnt !== c1});
    @(posedge CLK);
    idle <= 1'b0;
    // Sync output, both polarities, and with the driver disabled
    wr(OFS_CTRL, 16'h0000); cfg(16'h8100); window;
    rng("sync out pulses", 9, 11, seen);
    pin_chk("sync oe on", 1'b1, soe);
    wr(OFS_CTRL, 16'h0000); inv <= 1'b1; wr(OFS_CTRL, 16'h0300);
    pin_chk("inverted idle", 1'b1, sout);
    cfg(16'h8300); window;
    rng("inverted pulses", 9, 11, seen);
    wr(OFS_CTRL, 16'h0000); inv <= 1'b0; cfg(16'h8000); window;
    rng("disabled pulses", 0, 0, seen);
    pin_chk("sync oe off", 1'b0, soe);
    // period kept well above the sync pulse spacing
    wr(OFS_CTRL, 16'h0400); wr(OFS_PERIOD, 16'h00ff);
    cfg(16'h8000); climb; pulse(3'h0);
    cnt_in("sync ignored", 41, 65535);
    for (int s = 0; s < 8; s++) begin
      wr(OFS_CTRL, 16'h0000);
      inv <= s[0];
      cfg(16'h8080 | 16'(s << 4) | (s[0] ? 16'h0200 : 16'h0000));
      climb; pulse(3'(s + 1));
      cnt_in("other pin", 41, 65535);
      pulse(3'(s));
      cnt_in("sync restart", 0, 8);
    end
    wr(OFS_CTRL, 16'h0000); inv <= 1'b0;
    // Special events: postscale, pending flag, interrupt
    wr(OFS_CTRL, 16'h0400); wr(OFS_PERIOD, 16'h0009);
    wr(OFS_COMPARE, 16'h0003); wr(OFS_MASK, 16'h0001);
    for (int p = 0; p < 4; p += 3) begin
      cfg(16'h8800 | 16'(p)); window;
      rng("postscaled", 10 / (p + 1) - 1, 10 / (p + 1) + 1, trig_n);
    end
    rd(OFS_CTRL); chk("pending set", 16'h0001, 16'(q[BIT_SE_PEND]));
    pin_chk("irq raised", 1'b1, irq);
    wr(OFS_CTRL, 16'h0800); wr(OFS_STATUS, 16'h0007);
    rd(OFS_CTRL); chk("pending clear", 16'h0000, 16'(q[BIT_SE_PEND]));
    pin_chk("irq cleared", 1'b0, irq);
    wr(OFS_MASK, 16'h0000); cfg(16'h8800);
    repeat (30) @(posedge CLK);
    pin_chk("irq masked", 1'b0, irq);
    rd(OFS_STATUS); chk("status kept", 16'h0001, 16'(q[ST_SPECIAL]));
    wr(OFS_CTRL, 16'h0000); wr(OFS_STATUS, 16'h0007);
    wr(OFS_MASK, 16'h0001); cfg(16'h8000);
    repeat (30) @(posedge CLK);
    rd(OFS_CTRL); chk("event blocked", 16'h0000, 16'(q[BIT_SE_PEND]));
    pin_chk("irq blocked", 1'b0, irq);
    complete_run();
  end
endmodule : test_pwm_time_base
